/* File: bench/sdcmd_core_assertions.sv */
// port checker for the sdram command decoder
`timescale 1ns/100ps
`default_nettype none
module sdcmd_core_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_gate,
  input var sdcmd_pkg::sdcmd_pins_s pins,
  input var sdcmd_pkg::sdcmd_cmd_s cmd_out,
  input wire logic cmd_valid,
  input wire logic [11:0] mode_reg,
  input wire logic [11:0] refresh_row,
  input wire logic refresh_pulse,
  input wire logic [7:0] bank_state,
  input var sdcmd_pkg::sdcmd_pwr_e pwr_state
);
  import sdcmd_pkg::*;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // pin path is five edges from pin to answer
  AST_CS_IGNORE: assert property (pins.cs_n |-> ##5 !cmd_valid)
    else $error("command executed with select high");
  AST_ACT_OPEN: assert property (cmd_valid && cmd_out.cmd == SDCMD_ACT
    |-> bank_state[{cmd_out.bank, 1'b0} +: 2] == 2'h1)
    else $error("activate left bank not active");
  AST_PRE_ALL: assert property (cmd_valid && cmd_out.cmd == SDCMD_PRE
    && cmd_out.all_banks |-> ##[1:4] bank_state == 8'h00)
    else $error("precharge all left a bank open");
  AST_LMR_LOAD: assert property (cmd_valid && cmd_out.cmd == SDCMD_LMR
    |=> mode_reg == $past(pins.addr, 6))
    else $error("mode register not loaded from address");
  AST_REF_ROW: assert property (refresh_pulse |=> refresh_row != $past(refresh_row, 2))
    else $error("refresh row counter did not advance");
  AST_GATE_REQ: assert property (cmd_valid && cmd_out.cmd != SDCMD_REF
    |-> $past(clk_gate, 4) && $past(clk_gate, 5))
    else $error("command executed with gate low");
  AST_LOW_HOLD: assert property ((!clk_gate [*6]) ##0 pwr_state != SDCMD_P_RUN
    |=> pwr_state == $past(pwr_state))
    else $error("low-power state changed with gate low");
  AST_HIGH_EXIT: assert property (clk_gate [*7]
    |-> pwr_state inside {SDCMD_P_RUN, SDCMD_P_SELF})
    else $error("power-down or suspend kept with gate high");
endmodule
bind sdcmd_core sdcmd_core_assertions sdcmd_core_assertions_inst (.ref_clk, .rst, .clk_gate,
  .pins, .cmd_out, .cmd_valid, .mode_reg, .refresh_row, .refresh_pulse, .bank_state,
  .pwr_state);
`default_nettype wire

/* File: bench/sdcmd_core_tb_top.sv */
// self-checking bench for the sdram command decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WAIT_FOR(c) begin samples_checked++; w = 0; while ((c) !== 1'b1) begin \
  if (w == 40) begin n_errors++; finish_test(); end @(posedge ref_clk); #1; w++; end end
module sdcmd_core_tb_top;
  import sdcmd_pkg::*;
  typedef struct packed {
    sdcmd_cmd_e cmd; logic [1:0] bank; logic [11:0] addr; logic ok; logic bad; logic [7:0] st;
  } sdcmd_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_gate = 1'b1;
  logic mask = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [11:0] addr = 12'h000;
  sdcmd_cmd_e cmd = SDCMD_NOP;
  sdcmd_pins_s pins;
  sdcmd_cmd_s cmd_out;
  sdcmd_pwr_e pwr_state;
  logic cmd_valid, refresh_pulse, data_drive_en, data_write_en, xsr_busy, illegal_cmd;
  logic [11:0] mode_reg, refresh_row;
  logic [7:0] bank_state;
  int n_errors = 0;
  int samples_checked = 0;
  int w;
  // mode loads only with every bank idle; one read goes to a precharged bank and is flagged illegal
  sdcmd_row_s rows [13] = '{
    '{SDCMD_LMR, 2'h0, 12'h033, 1'b1, 1'b0, 8'h00},
    '{SDCMD_ACT, 2'h1, 12'habc, 1'b1, 1'b0, 8'h04},
    '{SDCMD_RD, 2'h1, 12'h005, 1'b1, 1'b0, 8'h0c},
    '{SDCMD_ACT, 2'h2, 12'h123, 1'b1, 1'b0, 8'h14},
    '{SDCMD_WR, 2'h2, 12'h407, 1'b1, 1'b0, 8'h34},
    '{SDCMD_NOP, 2'h0, 12'h000, 1'b0, 1'b0, 8'h04},
    '{SDCMD_PRE, 2'h1, 12'h000, 1'b1, 1'b0, 8'h08},
    '{SDCMD_RD, 2'h1, 12'h005, 1'b0, 1'b1, 8'h00},
    '{SDCMD_ACT, 2'h3, 12'hfff, 1'b1, 1'b0, 8'h40},
    '{SDCMD_PRE, 2'h1, 12'h400, 1'b1, 1'b0, 8'h80},
    '{SDCMD_REF, 2'h0, 12'h000, 1'b1, 1'b0, 8'h00},
    '{SDCMD_INHIBIT, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00},
    '{SDCMD_LMR, 2'h0, 12'h0a5, 1'b1, 1'b0, 8'h00}
  };
  sdcmd_ctrl_model sdcmd_ctrl_model_inst (.ref_clk, .cmd, .bank, .addr, .byte_mask(mask),
    .pins);
  sdcmd_core sdcmd_core_inst (.ref_clk, .rst, .clk_gate, .pins, .cmd_out, .cmd_valid,
    .mode_reg, .refresh_row, .refresh_pulse, .data_drive_en, .data_write_en, .bank_state,
    .pwr_state, .xsr_busy, .illegal_cmd);
  ////////////////////////////////////////
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // every request is held for two edges so that the pin filter takes it
  task automatic put(input sdcmd_cmd_e c, input logic [1:0] b, input logic [11:0] a);
    cmd = c;
    bank = b;
    addr = a;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // settles the banks first, then leaves just after the edge where the answer stands
  task automatic issue(input sdcmd_cmd_e c, input logic [1:0] b, input logic [11:0] a);
    put(SDCMD_NOP, 2'h0, 12'h000);
    put(c, b, a);
    put(SDCMD_NOP, 2'h0, 12'h000);
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    `CHK(bank_state, 8'h00)
    `CHK(pwr_state, SDCMD_P_RUN)
    put(SDCMD_NOP, 2'h0, 12'h000);
    foreach (rows[i]) begin
      issue(rows[i].cmd, rows[i].bank, rows[i].addr);
      `CHK(cmd_valid, rows[i].ok)
      `CHK(illegal_cmd, rows[i].bad)
      `CHK(bank_state, rows[i].st)
    end
    `CHK(mode_reg, 12'h0a5)
    $display("table done");
    issue(SDCMD_ACT, 2'h0, 12'h001);
    put(SDCMD_WR, 2'h0, 12'h000);
    put(SDCMD_TERM, 2'h0, 12'h000);
    put(SDCMD_NOP, 2'h0, 12'h000);
    @(posedge ref_clk);
    #1;
    `CHK(cmd_valid, 1'b1)
    `CHK(cmd_out.cmd, SDCMD_TERM)
    `CHK(bank_state[1:0], 2'h1)
    $display("terminate done");
    mask = 1'b1;
    put(SDCMD_WR, 2'h0, 12'h000);
    repeat (10) begin
      put(SDCMD_NOP, 2'h0, 12'h000);
      `CHK(data_write_en, 1'b0)
    end
    mask = 1'b0;
    put(SDCMD_WR, 2'h0, 12'h000);
    put(SDCMD_NOP, 2'h0, 12'h000);
    `WAIT_FOR(data_write_en)
    mask = 1'b1;
    put(SDCMD_RD, 2'h0, 12'h000);
    `WAIT_FOR(!data_drive_en)
    mask = 1'b0;
    put(SDCMD_NOP, 2'h0, 12'h000);
    `WAIT_FOR(data_drive_en)
    $display("mask done");
    put(SDCMD_RD, 2'h0, 12'h000);
    clk_gate = 1'b0;
    `WAIT_FOR(pwr_state == SDCMD_P_SUSP)
    clk_gate = 1'b1;
    `WAIT_FOR(pwr_state == SDCMD_P_RUN)
    $display("suspend done");
    issue(SDCMD_PRE, 2'h0, 12'h400);
    repeat (4) put(SDCMD_NOP, 2'h0, 12'h000);
    clk_gate = 1'b0;
    put(SDCMD_NOP, 2'h0, 12'h000);
    `WAIT_FOR(pwr_state == SDCMD_P_PDOWN)
    repeat (8) put(SDCMD_NOP, 2'h0, 12'h000);
    `CHK(pwr_state, SDCMD_P_PDOWN)
    clk_gate = 1'b1;
    `WAIT_FOR(pwr_state == SDCMD_P_RUN)
    $display("power-down done");
    clk_gate = 1'b0;
    put(SDCMD_REF, 2'h0, 12'h000);
    cmd = SDCMD_INHIBIT;
    `WAIT_FOR(pwr_state == SDCMD_P_SELF)
    repeat (8) put(SDCMD_INHIBIT, 2'h0, 12'h000);
    clk_gate = 1'b1;
    cmd = SDCMD_NOP;
    `WAIT_FOR(xsr_busy)
    `WAIT_FOR(!xsr_busy)
    `CHK(pwr_state, SDCMD_P_RUN)
    issue(SDCMD_ACT, 2'h3, 12'h010);
    `CHK(cmd_valid, 1'b1)
    $display("self-refresh done");
    finish_test();
  end
endmodule
`default_nettype wire

/* File: bench/sdcmd_ctrl_model.sv */
// command-issuing model of the external memory controller
`timescale 1ns/100ps
`default_nettype none
module sdcmd_ctrl_model (
  input wire logic ref_clk,
  input var sdcmd_pkg::sdcmd_cmd_e cmd,
  input wire logic [1:0] bank,
  input wire logic [11:0] addr,
  input wire logic byte_mask,
  output var sdcmd_pkg::sdcmd_pins_s pins
);
  import sdcmd_pkg::*;
  logic [11:0] noise_q = 12'h000;
  logic [2:0] strobe;
  ////////////////////////////////////////
  // unselected lines keep moving so a stale value never passes for a command
  always_ff @(posedge ref_clk) begin
    noise_q <= ~noise_q ^ 12'h5a5;
  end
  always_comb begin
    case (cmd)
      SDCMD_ACT: strobe = 3'h3;
      SDCMD_RD: strobe = 3'h5;
      SDCMD_WR: strobe = 3'h4;
      SDCMD_TERM: strobe = 3'h6;
      SDCMD_PRE: strobe = 3'h2;
      SDCMD_REF: strobe = 3'h1;
      SDCMD_LMR: strobe = 3'h0;
      SDCMD_INHIBIT: strobe = noise_q[2:0];
      default: strobe = 3'h7;
    endcase
    pins = {cmd == SDCMD_INHIBIT, strobe, bank,
      (cmd == SDCMD_INHIBIT) ? noise_q : addr, byte_mask};
  end
endmodule
`default_nettype wire

/* File: core/sdcmd_consts.svh */
// timing counts and field positions for the sdram command decoder
`ifndef SDCMD_CONSTS_SVH
`define SDCMD_CONSTS_SVH
`define SDCMD_ROW_W 12
`define SDCMD_COL_W 8
`define SDCMD_BANKS 4
`define SDCMD_FLAG_BIT 10
`define SDCMD_MASK_RD_DLY 2
`define SDCMD_BURST_LEN 4
`define SDCMD_XSR_NS 70
`define SDCMD_CLK_NS 10
`define SDCMD_XSR_CYC ((`SDCMD_XSR_NS + `SDCMD_CLK_NS - 1) / `SDCMD_CLK_NS)
`define SDCMD_PRE_NS 20
`define SDCMD_PRE_CYC ((`SDCMD_PRE_NS + `SDCMD_CLK_NS - 1) / `SDCMD_CLK_NS)
`endif

/* File: core/sdcmd_core.sv */
// sdram command decoder with per-bank and clock-gate state tracking
// How it works
// - chip select high: no command is registered, ongoing work continues
// - strobes all high with select low decode a no-operation
// - activate opens the twelve-bit row in the selected bank
// - row strobe high with column strobe low starts a read or write on the selected bank
// - low eight address bits give column; flag bit enables auto precharge once
// - precharge closes one bank, or all when the flag bit is high
// - burst terminate ends the burst; data pins stay driven that cycle
// - load mode register stores the twelve address bits
// - refresh is auto refresh with gate high, self-refresh entry with gate low
// - refresh rows come from an internal counter, other inputs ignored
// - mask low enables data; acts at once on writes, two clocks on reads
// - commands execute only with clock gate high at both edges
// - gate low at both edges keeps the current low-power state
// - gate falling with nop and banks idle enters power-down; rise exits
// - gate falling with auto refresh and banks idle enters self-refresh
// - gate falling during a burst suspends; rising resumes next edge
// - idle bank accepts activate, refresh, mode load, precharge
// - active bank accepts read, write, precharge
// - read burst accepts read, write, terminate; precharge truncates
// - write burst accepts read, write, terminate; precharge truncates
`include "sdcmd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sdcmd_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_gate,
  input var sdcmd_pkg::sdcmd_pins_s pins,
  output sdcmd_pkg::sdcmd_cmd_s cmd_out,
  output logic cmd_valid,
  output logic [11:0] mode_reg,
  output logic [11:0] refresh_row,
  output logic refresh_pulse,
  output logic data_drive_en,
  output logic data_write_en,
  output logic [7:0] bank_state,
  output sdcmd_pkg::sdcmd_pwr_e pwr_state,
  output logic xsr_busy,
  output logic illegal_cmd
);
  import sdcmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three stages, change taken when stages two and three agree
  // a command must stand for two edges to qualify; a one-edge glitch is dropped
  sdcmd_pins_s p1_q, p2_q, p3_q, pin_d, pin_q;
  logic g1_q, g2_q, g3_q, gate_d, gate_q, gate_prev_q;
  // fresh marks the single cycle in which a newly qualified value is taken
  logic fresh_d, fresh_q;

  always_comb begin
    pin_d = (p2_q == p3_q) ? p3_q : pin_q;
    gate_d = (g2_q == g3_q) ? g3_q : gate_q;
    fresh_d = (pin_d != pin_q);
  end

  always_ff @(posedge ref_clk) begin
    p1_q <= pins;
    p2_q <= p1_q;
    p3_q <= p2_q;
    g1_q <= clk_gate;
    g2_q <= g1_q;
    g3_q <= g2_q;
    if (rst) begin
      pin_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      gate_q <= 1'b1;
      gate_prev_q <= 1'b1;
      fresh_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      fresh_q <= fresh_d;
      gate_q <= gate_d;
      gate_prev_q <= gate_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic sdcmd_cmd_e decode(input sdcmd_pins_s p);
    if (p.cs_n) begin
      decode = SDCMD_INHIBIT;
    end else begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: decode = SDCMD_NOP;
        3'h3: decode = SDCMD_ACT;
        3'h5: decode = SDCMD_RD;
        3'h4: decode = SDCMD_WR;
        3'h6: decode = SDCMD_TERM;
        3'h2: decode = SDCMD_PRE;
        3'h1: decode = SDCMD_REF;
        default: decode = SDCMD_LMR;
      endcase
    end
  endfunction

  function automatic logic is_quiet(input sdcmd_cmd_e c);
    is_quiet = (c == SDCMD_INHIBIT) || (c == SDCMD_NOP);
  endfunction

  sdcmd_cmd_e cmd, raw_cmd;
  logic run, all_idle, any_burst;
  assign raw_cmd = decode(pin_q);
  // a held command runs once; repeating one needs some change on the pins between the two
  assign cmd = (fresh_q || is_quiet(raw_cmd)) ? raw_cmd : SDCMD_NOP;

  ////////////////////////////////////////////////////////////////////////////
  // power state and per-bank state
  sdcmd_pwr_e pwr_q, pwr_d;
  sdcmd_bank_e bank_q [`SDCMD_BANKS], bank_d [`SDCMD_BANKS];
  logic [2:0] btimer_q [`SDCMD_BANKS], btimer_d [`SDCMD_BANKS];
  logic [3:0] xsr_q, xsr_d;
  logic [1:0] nop_cnt_q, nop_cnt_d;
  logic [1:0] last_bank_q, last_bank_d;
  sdcmd_cmd_s cmd_d;
  logic valid_d, illegal_d, ref_d;
  logic [11:0] mode_d, rrow_d;
  logic [1:0] mask_pipe_q, mask_pipe_d;
  logic wen_d, den_d;

  always_comb begin
    all_idle = 1'b1;
    any_burst = 1'b0;
    for (int b = 0; b < `SDCMD_BANKS; b++) begin
      if (bank_q[b] != SDCMD_B_IDLE) all_idle = 1'b0;
      if (bank_q[b] == SDCMD_B_READ || bank_q[b] == SDCMD_B_WRITE ||
          bank_q[b] == SDCMD_B_AP) any_burst = 1'b1;
    end
  end

  // commands execute only in run state with gate high now and before
  assign run = (pwr_q == SDCMD_P_RUN) && gate_q && gate_prev_q && (xsr_q == 4'h0);

  always_comb begin
    pwr_d = pwr_q;
    xsr_d = (xsr_q != 4'h0) ? xsr_q - 4'h1 : 4'h0;
    nop_cnt_d = nop_cnt_q;
    last_bank_d = last_bank_q;
    bank_d = bank_q;
    btimer_d = btimer_q;
    cmd_d = '{cmd: cmd, bank: pin_q.bank_select, row: pin_q.addr,
              col: pin_q.addr[`SDCMD_COL_W-1:0], auto_pre: pin_q.addr[`SDCMD_FLAG_BIT],
              all_banks: pin_q.addr[`SDCMD_FLAG_BIT]};
    valid_d = 1'b0;
    illegal_d = 1'b0;
    ref_d = 1'b0;
    mode_d = mode_reg;
    rrow_d = refresh_row;
    // bank timers run only while clock is not gated off
    if (pwr_q == SDCMD_P_RUN) begin
      for (int b = 0; b < `SDCMD_BANKS; b++) begin
        if (btimer_q[b] != 3'h0) begin
          btimer_d[b] = btimer_q[b] - 3'h1;
        end else if (bank_q[b] == SDCMD_B_PRECH) begin
          bank_d[b] = SDCMD_B_IDLE;
        end else if (bank_q[b] == SDCMD_B_READ || bank_q[b] == SDCMD_B_WRITE) begin
          bank_d[b] = SDCMD_B_ACTIVE;
        end else if (bank_q[b] == SDCMD_B_AP) begin
          bank_d[b] = SDCMD_B_PRECH;
          btimer_d[b] = 3'(`SDCMD_PRE_CYC);
        end
      end
    end
    // gate and pins share one filter depth, so a gate edge meets its own command
    case (pwr_q)
      SDCMD_P_PDOWN: if (gate_q && is_quiet(cmd)) pwr_d = SDCMD_P_RUN;
      SDCMD_P_SUSP: if (gate_q) pwr_d = SDCMD_P_RUN;
      SDCMD_P_SELF: begin
        if (gate_q && is_quiet(cmd)) begin
          pwr_d = SDCMD_P_RUN;
          xsr_d = 4'(`SDCMD_XSR_CYC);
          nop_cnt_d = 2'h0;
        end else if (!gate_q) begin
          // the internal row counter steps every cycle while the gate stays low
          rrow_d = refresh_row + 12'h001;
          ref_d = 1'b1;
        end
      end
      default: begin
        if (xsr_q != 4'h0) begin
          // during exit recovery only quiet commands are legal
          if (!is_quiet(cmd)) illegal_d = 1'b1;
          else if (cmd == SDCMD_NOP && nop_cnt_q != 2'h2) nop_cnt_d = nop_cnt_q + 2'h1;
          if (xsr_q == 4'h1 && nop_cnt_d < 2'h2) illegal_d = 1'b1;
        end else if (gate_prev_q && !gate_q) begin
          // a falling gate is judged before any command of the same cycle
          if (cmd == SDCMD_REF && all_idle) begin
            pwr_d = SDCMD_P_SELF;
            rrow_d = refresh_row + 12'h001;
            ref_d = 1'b1;
          end else if (is_quiet(cmd) && all_idle) begin
            pwr_d = SDCMD_P_PDOWN;
          end else if (any_burst) begin
            pwr_d = SDCMD_P_SUSP;
          end else begin
            illegal_d = 1'b1;
          end
        end else if (run && !is_quiet(cmd)) begin
          valid_d = 1'b1;
          case (cmd)
            SDCMD_ACT: begin
              if (bank_q[pin_q.bank_select] == SDCMD_B_IDLE)
                bank_d[pin_q.bank_select] = SDCMD_B_ACTIVE;
              else illegal_d = 1'b1;
            end
            SDCMD_RD, SDCMD_WR: begin
              if (bank_q[pin_q.bank_select] inside {SDCMD_B_ACTIVE, SDCMD_B_READ,
                  SDCMD_B_WRITE}) begin
                bank_d[pin_q.bank_select] = pin_q.addr[`SDCMD_FLAG_BIT] ? SDCMD_B_AP :
                  (cmd == SDCMD_RD ? SDCMD_B_READ : SDCMD_B_WRITE);
                btimer_d[pin_q.bank_select] = 3'(`SDCMD_BURST_LEN - 1);
                last_bank_d = pin_q.bank_select;
              end else illegal_d = 1'b1;
            end
            SDCMD_TERM: begin
              // terminate follows the most recent burst, whatever its bank
              if (bank_q[last_bank_q] inside {SDCMD_B_READ, SDCMD_B_WRITE}) begin
                bank_d[last_bank_q] = SDCMD_B_ACTIVE;
                btimer_d[last_bank_q] = 3'h0;
              end else illegal_d = 1'b1;
            end
            SDCMD_PRE: begin
              // precharging an idle bank is a no-operation for that bank
              for (int b = 0; b < `SDCMD_BANKS; b++) begin
                if (pin_q.addr[`SDCMD_FLAG_BIT] || pin_q.bank_select == 2'(b)) begin
                  if (bank_q[b] inside {SDCMD_B_ACTIVE, SDCMD_B_READ, SDCMD_B_WRITE}) begin
                    bank_d[b] = SDCMD_B_PRECH;
                    btimer_d[b] = 3'(`SDCMD_PRE_CYC);
                  end else if (bank_q[b] != SDCMD_B_IDLE) begin
                    illegal_d = 1'b1;
                  end
                end
              end
            end
            SDCMD_REF: begin
              if (all_idle) begin
                rrow_d = refresh_row + 12'h001;
                ref_d = 1'b1;
              end else illegal_d = 1'b1;
            end
            default: begin
              if (all_idle) mode_d = pin_q.addr;
              else illegal_d = 1'b1;
            end
          endcase
          // an illegal command is reported but never counted as executed
          if (illegal_d) valid_d = 1'b0;
        end
      end
    endcase
    // mask: writes see it at once, reads two clocks after registration
    mask_pipe_d = {mask_pipe_q[0], pin_q.byte_mask};
    wen_d = !pin_q.byte_mask && (bank_q[last_bank_q] == SDCMD_B_WRITE || cmd == SDCMD_WR);
    den_d = !mask_pipe_q[`SDCMD_MASK_RD_DLY-1] || (cmd == SDCMD_TERM && run);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_q <= SDCMD_P_RUN;
      xsr_q <= 4'h0;
      nop_cnt_q <= 2'h0;
      last_bank_q <= 2'h0;
      for (int b = 0; b < `SDCMD_BANKS; b++) begin
        bank_q[b] <= SDCMD_B_IDLE;
        btimer_q[b] <= 3'h0;
      end
      cmd_out <= '{cmd: SDCMD_INHIBIT, default: '0};
      cmd_valid <= 1'b0;
      illegal_cmd <= 1'b0;
      refresh_pulse <= 1'b0;
      mode_reg <= 12'h000;
      refresh_row <= 12'h000;
      mask_pipe_q <= 2'h3;
      data_write_en <= 1'b0;
      data_drive_en <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      xsr_q <= xsr_d;
      nop_cnt_q <= nop_cnt_d;
      last_bank_q <= last_bank_d;
      bank_q <= bank_d;
      btimer_q <= btimer_d;
      cmd_out <= cmd_d;
      cmd_valid <= valid_d;
      illegal_cmd <= illegal_d;
      refresh_pulse <= ref_d;
      mode_reg <= mode_d;
      refresh_row <= rrow_d;
      mask_pipe_q <= mask_pipe_d;
      data_write_en <= wen_d;
      data_drive_en <= den_d;
    end
  end

  always_comb begin
    for (int b = 0; b < `SDCMD_BANKS; b++) bank_state[2*b +: 2] = bank_q[b][1:0];
  end
  assign pwr_state = pwr_q;
  assign xsr_busy = (xsr_q != 4'h0);
endmodule
`default_nettype wire

/* File: core/sdcmd_pkg.sv */
// types for the sdram command decoder
package sdcmd_pkg;
  typedef enum logic [3:0] {
    SDCMD_INHIBIT = 4'h0, SDCMD_NOP = 4'h1, SDCMD_ACT = 4'h2, SDCMD_RD = 4'h3,
    SDCMD_WR = 4'h4, SDCMD_TERM = 4'h5, SDCMD_PRE = 4'h6, SDCMD_REF = 4'h7,
    SDCMD_LMR = 4'h8
  } sdcmd_cmd_e;
  typedef enum logic [2:0] {
    SDCMD_B_IDLE = 3'h0, SDCMD_B_ACTIVE = 3'h1, SDCMD_B_READ = 3'h3,
    SDCMD_B_WRITE = 3'h2, SDCMD_B_PRECH = 3'h6, SDCMD_B_AP = 3'h7
  } sdcmd_bank_e;
  typedef enum logic [1:0] {
    SDCMD_P_RUN = 2'h0, SDCMD_P_PDOWN = 2'h1, SDCMD_P_SELF = 2'h3, SDCMD_P_SUSP = 2'h2
  } sdcmd_pwr_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [11:0] addr;
    logic byte_mask;
  } sdcmd_pins_s;
  typedef struct packed {
    sdcmd_cmd_e cmd;
    logic [1:0] bank;
    logic [11:0] row;
    logic [7:0] col;
    logic auto_pre;
    logic all_banks;
  } sdcmd_cmd_s;
endpackage
